// >>> adc_seq_map.vh
// register offsets, field positions, reset values and timing counts
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// ========================================================
// register offsets
`define ADDR_CONTROL_A       4'h0
`define ADDR_CONTROL_B       4'h1
`define ADDR_RESULT_HIGH     4'h2
`define ADDR_RESULT_LOW      4'h3
`define ADDR_STATUS          4'h4
`define ADDR_PORT_DATA       4'h5
`define ADDR_ANALOG_MASK     4'h6
`define ADDR_PIN_DIRECTION   4'h7

// ========================================================
// control a fields
`define CA_CLKSEL_HI         7
`define CA_CLKSEL_LO         6
`define CA_CHAN_HI           5
`define CA_CHAN_LO           3
`define CA_GO                2
`define CA_POWER             0
// control b fields
`define CB_FORMAT            7
`define CB_CLKSEL2           6
`define CB_PORTCFG_HI        3
`define CB_PORTCFG_LO        0
// status fields
`define ST_DONE              0

// ========================================================
// reset values
`define RST_CONTROL_A        8'h00
`define RST_CONTROL_B        8'h00
`define RST_ANALOG_MASK      8'hff
`define RST_PIN_DIRECTION    8'hff

// ========================================================
// clock select codes and timing
`define CLKSEL_RC            2'h3
`define CONV_TADS            4'hc
`define RECOVER_TADS         4'h2
`define RESULT_BITS          10

`endif

// >>> conv_clock_gen.v
// conversion clock enable generator: divided system clock or rc tick
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.vh"

module conv_clock_gen (
	input  wire       ref_clk,
	input  wire       rst,
	input  wire       run,
	input  wire       restart,
	input  wire [2:0] clk_select,
	input  wire       rc_osc_tick,
	output reg        tad_tick
);

	// ========================================================
	// divide ratio decode
	function [6:0] div_ratio;
		input [2:0] sel;
		begin
			case (sel)
			3'h0:    div_ratio = 7'h02;
			3'h4:    div_ratio = 7'h04;
			3'h1:    div_ratio = 7'h08;
			3'h5:    div_ratio = 7'h10;
			3'h2:    div_ratio = 7'h20;
			3'h6:    div_ratio = 7'h40;
			default: div_ratio = 7'h02;
			endcase
		end
	endfunction

	reg  [6:0] cnt_ff;
	wire       use_rc;
	wire [6:0] last;

	assign use_rc = (clk_select[1:0] == `CLKSEL_RC);
	assign last   = div_ratio(clk_select) - 7'h01;

	// ========================================================
	// restart aligns the first divided-clock period to the start of a conversion
	always @(posedge ref_clk) begin
		if (rst || !run || restart) begin
			cnt_ff   <= 7'h00;
			tad_tick <= 1'b0;
		end else if (use_rc) begin
			cnt_ff   <= 7'h00;
			tad_tick <= rc_osc_tick;
		end else if (cnt_ff == last) begin
			cnt_ff   <= 7'h00;
			tad_tick <= 1'b1;
		end else begin
			cnt_ff   <= cnt_ff + 7'h01;
			tad_tick <= 1'b0;
		end
	end

endmodule // conv_clock_gen
`default_nettype wire

// >>> sar_core.v
// successive approximation stepper with post-conversion recovery
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.vh"

module sar_core (
	input  wire       ref_clk,
	input  wire       rst,
	input  wire       tad_tick,
	input  wire       start,
	input  wire       abort,
	input  wire       cmp_high,
	output wire       busy,
	output wire       recovering,
	output reg        done,
	output reg  [9:0] result,
	output reg  [9:0] dac_code,
	output reg        hold_connect
);

	localparam ST_IDLE  = 2'h0;
	localparam ST_CONV  = 2'h1;
	localparam ST_RECOV = 2'h2;

	reg [1:0] state_ff;
	reg [3:0] cnt_ff;
	reg [9:0] sar_ff;
	reg [9:0] mask_ff;
	reg [9:0] nxt_sar;

	assign busy       = (state_ff == ST_CONV);
	assign recovering = (state_ff == ST_RECOV);

	always @* begin
		nxt_sar = cmp_high ? dac_code : sar_ff;
	end

	// ========================================================
	// one tad to settle, ten decisions, one tad to finish
	always @(posedge ref_clk) begin
		if (rst) begin
			state_ff     <= ST_IDLE;
			cnt_ff       <= 4'h0;
			sar_ff       <= 10'h000;
			mask_ff      <= 10'h000;
			dac_code     <= 10'h000;
			result       <= 10'h000;
			done         <= 1'b0;
			hold_connect <= 1'b1;
		end else begin
			done <= 1'b0;
			case (state_ff)
			ST_IDLE: begin
				if (start) begin
					state_ff     <= ST_CONV;
					cnt_ff       <= 4'h0;
					hold_connect <= 1'b0;
				end
			end
			ST_CONV: begin
				if (abort) begin
					state_ff <= ST_RECOV;
					cnt_ff   <= 4'h0;
				end else if (tad_tick) begin
					cnt_ff <= cnt_ff + 4'h1;
					if (cnt_ff == 4'h0) begin
						sar_ff   <= 10'h000;
						mask_ff  <= 10'h200;
						dac_code <= 10'h200;
					end else if (cnt_ff == `CONV_TADS - 4'h1) begin
						result   <= sar_ff;
						done     <= 1'b1;
						state_ff <= ST_RECOV;
						cnt_ff   <= 4'h0;
					end else begin
						sar_ff   <= nxt_sar;
						mask_ff  <= mask_ff >> 1;
						dac_code <= nxt_sar | (mask_ff >> 1);
					end
				end
			end
			ST_RECOV: begin
				if (tad_tick) begin
					cnt_ff <= cnt_ff + 4'h1;
					if (cnt_ff == `RECOVER_TADS - 4'h1) begin
						state_ff     <= ST_IDLE;
						hold_connect <= 1'b1;
					end
				end
			end
			default: begin
				state_ff     <= ST_IDLE;
				hold_connect <= 1'b1;
			end
			endcase
		end
	end

endmodule // sar_core
`default_nettype wire

// >>> adc_conversion_sequencer.v
// converter control: registers, start and abort, result justification
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.vh"

module adc_conversion_sequencer (
	input  wire       ref_clk,
	input  wire       rst,
	input  wire [3:0] addr,
	input  wire [7:0] wr_data,
	input  wire       wr_en,
	input  wire       rd_en,
	output reg  [7:0] rd_data,
	input  wire       rc_osc_tick,
	input  wire       cmp_high,
	input  wire [7:0] pin_in,
	output wire [9:0] dac_code,
	output wire       hold_capacitor_connect,
	output reg  [2:0] input_channel_select,
	output reg        converter_power_enable,
	output reg        conversion_done_flag,
	output reg  [7:0] pin_direction_bits
);

	// ========================================================
	// justification of the ten-bit result into the pair
	function [15:0] justify;
		input [9:0] res;
		input       right;
		begin
			if (right)
				justify = {6'h00, res};
			else
				justify = {res, 6'h00};
		end
	endfunction

	// ========================================================
	// register index match, shared by every write decode
	function hit;
		input [3:0] a;
		input [3:0] idx;
		begin
			hit = (a == idx);
		end
	endfunction

	// ========================================================
	// control state
	reg  [1:0] clk_sel_lo_ff;
	reg        clk_sel_hi_ff;
	reg        go_ff;
	reg        format_ff;
	reg  [3:0] port_cfg_ff;
	reg  [7:0] analog_mask_ff;
	reg  [7:0] result_high_byte;
	reg  [7:0] result_low_byte;

	wire       busy;
	wire       recovering;
	wire       conv_done;
	wire [9:0] conv_result;
	wire       tad_tick;
	wire [2:0] conv_clock_select;
	wire [15:0] packed_result;

	wire        wr_ctrl_a;
	wire        wr_ctrl_b;
	wire        wr_status;
	wire        wr_res_high;
	wire        wr_res_low;
	wire        wr_mask;
	wire        wr_dir;
	wire        start_req;
	wire        abort_req;
	wire        clk_run;
	wire        result_load;
	wire [7:0]  ctl_a_rst;
	wire [7:0]  ctl_b_rst;
	wire [7:0]  ctl_a_image;
	wire [7:0]  ctl_b_image;
	wire [7:0]  port_image;
	reg  [7:0]  nxt_rd_data;
	reg  [7:0]  nxt_result_high;
	reg  [7:0]  nxt_result_low;

	// reset images of the control registers, sliced field by field below
	assign ctl_a_rst = `RST_CONTROL_A;
	assign ctl_b_rst = `RST_CONTROL_B;

	assign conv_clock_select = {clk_sel_hi_ff, clk_sel_lo_ff};
	assign wr_ctrl_a   = wr_en && hit(addr, `ADDR_CONTROL_A);
	assign wr_ctrl_b   = wr_en && hit(addr, `ADDR_CONTROL_B);
	assign wr_status   = wr_en && hit(addr, `ADDR_STATUS);
	assign wr_res_high = wr_en && hit(addr, `ADDR_RESULT_HIGH);
	assign wr_res_low  = wr_en && hit(addr, `ADDR_RESULT_LOW);
	assign wr_mask     = wr_en && hit(addr, `ADDR_ANALOG_MASK);
	assign wr_dir      = wr_en && hit(addr, `ADDR_PIN_DIRECTION);

	// enable must already be on from an earlier write; channel and pin
	// direction take no part in the decision
	assign start_req = wr_ctrl_a && wr_data[`CA_GO] && wr_data[`CA_POWER] &&
		converter_power_enable && !busy && !recovering;

	// clearing start or powering down while busy ends the conversion
	assign abort_req = busy && wr_ctrl_a &&
		(!wr_data[`CA_GO] || !wr_data[`CA_POWER]);

	assign packed_result = justify(conv_result, format_ff);

	// a power-down abort still needs its two recovery periods, so the
	// divider keeps running until the stepper is back to sampling
	assign clk_run = converter_power_enable || recovering;

	// completion never lands while powered down; the guard keeps the
	// pair as plain storage whenever the converter is off
	assign result_load = conv_done && converter_power_enable;

	// ========================================================
	// read images: unimplemented bits read as zero
	assign ctl_a_image = {clk_sel_lo_ff, input_channel_select, go_ff,
		1'b0, converter_power_enable};
	assign ctl_b_image = {format_ff, clk_sel_hi_ff, 2'h0, port_cfg_ff};
	assign port_image  = pin_in & ~analog_mask_ff;

	// ========================================================
	// conversion clock and stepper
	conv_clock_gen u_clk (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.run         (clk_run),
		.restart     (start_req),
		.clk_select  (conv_clock_select),
		.rc_osc_tick (rc_osc_tick),
		.tad_tick    (tad_tick)
	);

	sar_core u_sar (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.tad_tick     (tad_tick),
		.start        (start_req),
		.abort        (abort_req),
		.cmp_high     (cmp_high),
		.busy         (busy),
		.recovering   (recovering),
		.done         (conv_done),
		.result       (conv_result),
		.dac_code     (dac_code),
		.hold_connect (hold_capacitor_connect)
	);

	// ========================================================
	// control a fields
	always @(posedge ref_clk) begin
		if (rst) begin
			clk_sel_lo_ff          <= ctl_a_rst[`CA_CLKSEL_HI:`CA_CLKSEL_LO];
			input_channel_select   <= ctl_a_rst[`CA_CHAN_HI:`CA_CHAN_LO];
			converter_power_enable <= ctl_a_rst[`CA_POWER];
		end else if (wr_ctrl_a) begin
			clk_sel_lo_ff          <= wr_data[`CA_CLKSEL_HI:`CA_CLKSEL_LO];
			input_channel_select   <= wr_data[`CA_CHAN_HI:`CA_CHAN_LO];
			converter_power_enable <= wr_data[`CA_POWER];
		end
	end

	// ========================================================
	// control b fields
	always @(posedge ref_clk) begin
		if (rst) begin
			format_ff     <= ctl_b_rst[`CB_FORMAT];
			clk_sel_hi_ff <= ctl_b_rst[`CB_CLKSEL2];
			port_cfg_ff   <= ctl_b_rst[`CB_PORTCFG_HI:`CB_PORTCFG_LO];
		end else if (wr_ctrl_b) begin
			format_ff     <= wr_data[`CB_FORMAT];
			clk_sel_hi_ff <= wr_data[`CB_CLKSEL2];
			port_cfg_ff   <= wr_data[`CB_PORTCFG_HI:`CB_PORTCFG_LO];
		end
	end

	// ========================================================
	// analog mask and pin direction storage
	always @(posedge ref_clk) begin
		if (rst) begin
			analog_mask_ff     <= `RST_ANALOG_MASK;
			pin_direction_bits <= `RST_PIN_DIRECTION;
		end else begin
			if (wr_mask)
				analog_mask_ff <= wr_data;
			if (wr_dir)
				pin_direction_bits <= wr_data;
		end
	end

	// ========================================================
	// start bit: hardware clear on completion outranks software
	always @(posedge ref_clk) begin
		if (rst)
			go_ff <= ctl_a_rst[`CA_GO];
		else if (conv_done)
			go_ff <= 1'b0;
		else if (start_req)
			go_ff <= 1'b1;
		else if (abort_req)
			go_ff <= 1'b0;
		else if (wr_ctrl_a && !busy)
			go_ff <= 1'b0;
	end

	// ========================================================
	// done flag: a completion in the same cycle as a clear wins
	always @(posedge ref_clk) begin
		if (rst)
			conversion_done_flag <= 1'b0;
		else if (conv_done)
			conversion_done_flag <= 1'b1;
		else if (wr_status)
			conversion_done_flag <= wr_data[`ST_DONE];
	end

	// ========================================================
	// result pair next values: a completion outranks a software write
	always @* begin
		nxt_result_high = result_high_byte;
		nxt_result_low  = result_low_byte;
		if (result_load) begin
			nxt_result_high = packed_result[15:8];
			nxt_result_low  = packed_result[7:0];
		end else begin
			if (wr_res_high)
				nxt_result_high = wr_data;
			if (wr_res_low)
				nxt_result_low = wr_data;
		end
	end

	// deliberately outside the reset so the pair survives it
	always @(posedge ref_clk) begin
		result_high_byte <= nxt_result_high;
		result_low_byte  <= nxt_result_low;
	end

	// ========================================================
	// read mux: data stands only in the cycle after the strobe; the
	// extra cycle buys an output taken straight from a flop
	always @* begin
		nxt_rd_data = 8'h00;
		if (rd_en) begin
			case (addr)
			`ADDR_CONTROL_A:
				nxt_rd_data = ctl_a_image;
			`ADDR_CONTROL_B:
				nxt_rd_data = ctl_b_image;
			`ADDR_RESULT_HIGH:
				nxt_rd_data = result_high_byte;
			`ADDR_RESULT_LOW:
				nxt_rd_data = result_low_byte;
			`ADDR_STATUS:
				nxt_rd_data = {7'h00, conversion_done_flag};
			`ADDR_PORT_DATA:
				nxt_rd_data = port_image;
			`ADDR_ANALOG_MASK:
				nxt_rd_data = analog_mask_ff;
			`ADDR_PIN_DIRECTION:
				nxt_rd_data = pin_direction_bits;
			default:
				nxt_rd_data = 8'h00;
			endcase
		end
	end

	always @(posedge ref_clk) begin
		if (rst)
			rd_data <= 8'h00;
		else
			rd_data <= nxt_rd_data;
	end

endmodule // adc_conversion_sequencer
`default_nettype wire

// >>> adc_seq_asserts.sv
// concurrent checks on the converter sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.vh"

// ====================
// port checker
module adc_seq_asserts (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] rd_data,
	input wire logic [7:0] pin_in,
	input wire logic       hold_capacitor_connect,
	input wire logic [2:0] input_channel_select,
	input wire logic       converter_power_enable,
	input wire logic       conversion_done_flag,
	input wire logic [7:0] pin_direction_bits
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_ctl_wr;
		wr_en && addr == `ADDR_CONTROL_A;
	endsequence
	// 64 divider gives a 128 cycle recovery, so 300 leaves margin
	sequence s_recover;
		!hold_capacitor_connect ##[1:300] hold_capacitor_connect;
	endsequence

	property p_rd_idle;
		!rd_en |=> rd_data == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_unmapped;
		rd_en && addr[3] |=> rd_data == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_port_mask;
		rd_en && addr == `ADDR_PORT_DATA |=> (rd_data & ~$past(pin_in)) == 8'h00;
	endproperty
	a_port_mask: assert property (p_port_mask) else $error("port data");
	property p_ctl_wr;
		s_ctl_wr |=> converter_power_enable == $past(wr_data[0])
			&& input_channel_select == $past(wr_data[5:3]);
	endproperty
	a_ctl_wr: assert property (p_ctl_wr) else $error("control write");
	property p_ctl_rd;
		rd_en && addr == `ADDR_CONTROL_A |=> rd_data[1] == 1'b0
			&& rd_data[0] == $past(converter_power_enable);
	endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control read");
	property p_hold_start;
		$fell(hold_capacitor_connect) |-> $past(converter_power_enable)
			&& $past(wr_en && addr == `ADDR_CONTROL_A && wr_data[2]);
	endproperty
	a_hold_start: assert property (p_hold_start) else $error("hold");
	property p_conv_len;
		$rose(conversion_done_flag) |-> !$past(hold_capacitor_connect, 1)
			&& !$past(hold_capacitor_connect, 23);
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("short run");
	property p_done_rec;
		$rose(conversion_done_flag) |-> s_recover;
	endproperty
	a_done_rec: assert property (p_done_rec) else $error("no recovery");
	property p_abort_rec;
		s_ctl_wr ##0 !wr_data[2] |-> s_recover or hold_capacitor_connect;
	endproperty
	a_abort_rec: assert property (p_abort_rec) else $error("abort");
	property p_done_clear;
		$fell(conversion_done_flag) |-> $past(wr_en && addr == `ADDR_STATUS);
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("done");
	property p_dir_wr;
		wr_en && addr == `ADDR_PIN_DIRECTION |=> pin_direction_bits == $past(wr_data);
	endproperty
	a_dir_wr: assert property (p_dir_wr) else $error("direction write");
	property p_reset;
		disable iff (1'b0) rst |=> !converter_power_enable && hold_capacitor_connect
			&& !conversion_done_flag && pin_direction_bits == 8'hff;
	endproperty
	a_reset: assert property (p_reset) else $error("reset values");
endmodule // adc_seq_asserts
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.vh"

// ====================
// bench
module testbench;
	typedef struct {
		logic [9:0] vin;
		logic       fmt;
		logic [2:0] sel;
		logic [2:0] ch;
		logic [7:0] dir;
		int         n;
	} row_t;
	logic       ref_clk = 1'b0;
	logic       rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wr_data = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic       rc_osc_tick = 1'b0;
	logic       cmp_high = 1'b0;
	logic [7:0] pin_in = 8'ha5;
	logic [9:0] vin = 10'h000;
	logic [2:0] rc_cnt = 3'h0;
	wire  [7:0] rd_data;
	wire  [9:0] dac_code;
	wire        hold;
	wire  [2:0] chan;
	wire        power;
	wire        done;
	wire  [7:0] dir;
	int         error_cnt = 0;
	int         n_compared = 0;
	row_t       rows[7];
	int         d[7];
	int         k;
	logic [7:0] c;
	logic [15:0] j;

	adc_conversion_sequencer adc_conversion_sequencer_inst (.ref_clk(ref_clk),
		.rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .rc_osc_tick(rc_osc_tick),
		.cmp_high(cmp_high), .pin_in(pin_in), .dac_code(dac_code),
		.hold_capacitor_connect(hold), .input_channel_select(chan),
		.converter_power_enable(power), .conversion_done_flag(done),
		.pin_direction_bits(dir));

	always #2.5 ref_clk = ~ref_clk;
	// rc tick every 7 cycles; comparator lags dac by one cycle, fine for n>=2
	always @(posedge ref_clk) begin
		rc_cnt <= (rc_cnt == 3'h6) ? 3'h0 : rc_cnt + 3'h1;
		rc_osc_tick <= (rc_cnt == 3'h6);
		cmp_high <= (vin >= dac_code);
	end

	// ====================
	// tasks
	task give_verdict;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("FAIL %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= v;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask
	task rdc(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 chk(rd_data, e);
	endtask
	task waith(output int n);
		n = 0;
		while (hold !== 1'b1 && n < 2000) begin
			@(posedge ref_clk);
			n++;
		end
		chk(8'(n < 2000), 8'h01);
	endtask
	task conv(input logic [7:0] cv, output int n);
		wr(`ADDR_CONTROL_A, cv);
		repeat (4) @(posedge ref_clk);
		wr(`ADDR_CONTROL_A, cv | 8'h04);
		#1 chk({7'h00, hold}, 8'h00);
		n = 0;
		while (done !== 1'b1 && n < 2000) begin
			@(posedge ref_clk);
			n++;
		end
		chk(8'(n < 2000), 8'h01);
	endtask
	function logic [15:0] just(input logic [9:0] x, input logic f);
		just = f ? {6'h00, x} : {x, 6'h00};
	endfunction

	// ====================
	// sequence
	initial begin
		rows[0] = '{10'h2c5, 1'h1, 3'h0, 3'h0, 8'hff, 2};
		rows[1] = '{10'h13a, 1'h0, 3'h4, 3'h1, 8'h00, 4};
		rows[2] = '{10'h3ff, 1'h1, 3'h1, 3'h2, 8'hff, 8};
		rows[3] = '{10'h000, 1'h0, 3'h5, 3'h3, 8'h0f, 16};
		rows[4] = '{10'h201, 1'h1, 3'h2, 3'h7, 8'hff, 32};
		rows[5] = '{10'h1fe, 1'h0, 3'h6, 3'h5, 8'hf0, 64};
		rows[6] = '{10'h0aa, 1'h1, 3'h3, 3'h6, 8'hff, 0};
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		rdc(`ADDR_CONTROL_A, 8'h00);
		rdc(`ADDR_CONTROL_B, 8'h00);
		rdc(`ADDR_ANALOG_MASK, 8'hff);
		rdc(`ADDR_PIN_DIRECTION, 8'hff);
		rdc(`ADDR_PORT_DATA, 8'h00);
		wr(`ADDR_ANALOG_MASK, 8'h0f);
		rdc(`ADDR_PORT_DATA, 8'ha0);
		wr(4'hc, 8'hff);
		rdc(4'hc, 8'h00);
		for (int i = 0; i < 7; i++) begin
			vin = rows[i].vin;
			j = just(vin, rows[i].fmt);
			c = {rows[i].sel[1:0], rows[i].ch, 3'h1};
			wr(`ADDR_PIN_DIRECTION, rows[i].dir);
			wr(`ADDR_CONTROL_B, {rows[i].fmt, rows[i].sel[2], 6'h00});
			conv(c, d[i]);
			rdc(`ADDR_CONTROL_A, c);
			rdc(`ADDR_RESULT_HIGH, j[15:8]);
			rdc(`ADDR_RESULT_LOW, j[7:0]);
			rdc(`ADDR_STATUS, 8'h01);
			wr(`ADDR_STATUS, 8'h00);
			waith(k);
		end
		for (int i = 1; i < 6; i++)
			chk(8'(d[i] - d[0] == 12 * (rows[i].n - 2)), 8'h01);
		chk(8'(d[6] >= 77 && d[6] <= d[0] + 69), 8'h01);
		// abort mid-run: old result stays, hold returns after two ticks
		vin = 10'h155;
		wr(`ADDR_CONTROL_B, 8'h80);
		conv(8'h01, k);
		wr(`ADDR_STATUS, 8'h00);
		waith(k);
		vin = 10'h2aa;
		wr(`ADDR_CONTROL_A, 8'h05);
		repeat (6) @(posedge ref_clk);
		wr(`ADDR_CONTROL_A, 8'h01);
		waith(k);
		chk(8'(k >= 1 && k <= 7), 8'h01);
		rdc(`ADDR_RESULT_HIGH, 8'h01);
		rdc(`ADDR_RESULT_LOW, 8'h55);
		rdc(`ADDR_STATUS, 8'h00);
		conv(8'h01, k);
		rdc(`ADDR_RESULT_LOW, 8'haa);
		wr(`ADDR_STATUS, 8'h00);
		waith(k);
		// go in the same write as power-up is refused
		wr(`ADDR_CONTROL_A, 8'h00);
		wr(`ADDR_CONTROL_A, 8'h05);
		rdc(`ADDR_CONTROL_A, 8'h01);
		wr(`ADDR_CONTROL_A, 8'h00);
		wr(`ADDR_RESULT_HIGH, 8'h3c);
		wr(`ADDR_RESULT_LOW, 8'hc3);
		rdc(`ADDR_RESULT_HIGH, 8'h3c);
		rdc(`ADDR_RESULT_LOW, 8'hc3);
		// reset in mid-run aborts; result pair survives it
		wr(`ADDR_CONTROL_A, 8'h01);
		wr(`ADDR_CONTROL_A, 8'h05);
		repeat (8) @(posedge ref_clk);
		rst <= 1'b1;
		@(posedge ref_clk);
		rst <= 1'b0;
		rdc(`ADDR_CONTROL_A, 8'h00);
		rdc(`ADDR_RESULT_LOW, 8'hc3);
		give_verdict();
	end
	initial begin
		#200000;
		error_cnt++;
		give_verdict();
	end
endmodule // testbench

bind adc_conversion_sequencer adc_seq_asserts adc_seq_asserts_inst (
	.ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
	.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in),
	.hold_capacitor_connect(hold_capacitor_connect),
	.input_channel_select(input_channel_select),
	.converter_power_enable(converter_power_enable),
	.conversion_done_flag(conversion_done_flag),
	.pin_direction_bits(pin_direction_bits));
`default_nettype wire
